/* File: sat_pkg.sv */
// Purpose: shared types of the split auto-reload timer pair
// Assumes: nothing beyond SystemVerilog
// Notes: constants live in sat_timer_regs.svh
package sat_pkg;
	// ==========================================================
	// one timer instance as seen by the register port
	typedef struct packed {
		logic [7:0] ctl;
		logic [15:0] count;
		logic [15:0] reload;
	} sat_state_type;

	// write strobes into one instance
	typedef struct packed {
		logic ctl;
		logic cnt_lo;
		logic cnt_hi;
		logic rld_lo;
		logic rld_hi;
	} sat_wsel_type;

	// shared count and capture sources
	typedef struct packed {
		logic div12;
		logic ext8;
		logic lfo_fall;
	} sat_tick_type;
endpackage

/* File: sat_timer_pair.sv */
// Purpose: two split auto-reload timers behind a special function register port
// Assumes: one 50 MHz core clock; oscillator pins are asynchronous
// Notes: read data is registered and follows the address by one cycle
//
// Notes on behaviour
// - Each timer is a low and a high count byte forming one 16-bit counter plus two reload bytes.
// - With split mode off the timer runs as one 16-bit up-counter with auto-reload.
// - In 16-bit mode an overflow from FFFF loads both reload bytes and sets the high flag.
// - In 16-bit mode an interrupt follows each full overflow, and each low rollover if enabled.
// - In split mode the two bytes are separate 8-bit timers, each reloading from its own byte.
// - In split mode run control gates only the high byte; the low byte always counts.
// - Each byte counts on the core clock if selected, else core/12 or external oscillator/8.
// - The external oscillator is synchronised to the core clock before it is divided by eight.
// - In split mode each byte sets its own overflow flag when it overflows from FF and reloads.
// - In split mode an interrupt follows each high overflow, and each low one if enabled.
// - The hardware never clears the overflow flags; software clears them and checks both.
// - With capture and interrupts on, an oscillator falling edge copies the count to reload.
// - In 16-bit mode the low clock select drives the whole timer; the high select is ignored.
`timescale 1ns/1ns
`include "sat_timer_regs.svh"
module sat_timer_pair (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic [7:0] sfr_addr_in,
	input wire logic sfr_wr_in,
	input wire logic [7:0] sfr_wdata_in,
	output logic [7:0] sfr_rdata_out,
	input wire logic ext_osc_in,
	input wire logic lfo_in,
	input wire logic tb_irq_enable_in,
	input wire logic tc_irq_enable_in,
	output logic tb_irq_out,
	output logic tc_irq_out
);
	import sat_pkg::*;

	// ==========================================================
	// pin synchronisers: three stages, a change counts once stages two and three agree
	logic [2:0] ext_sync_q, lfo_sync_q;
	logic ext_lvl_q, ext_lvl_d, lfo_lvl_q, lfo_lvl_d;
	logic [2:0] ext_div_q, ext_div_d;
	logic [3:0] core_div_q, core_div_d;
	logic ext8_q, ext8_d, div12_q, div12_d, lfo_fall_q, lfo_fall_d;

	// prescalers; ticks are registered so every source has the same one-cycle latency
	always_comb begin
		ext_lvl_d = (ext_sync_q[1] == ext_sync_q[2]) ? ext_sync_q[2] : ext_lvl_q;
		lfo_lvl_d = (lfo_sync_q[1] == lfo_sync_q[2]) ? lfo_sync_q[2] : lfo_lvl_q;
		ext_div_d = ext_div_q;
		ext8_d = 1'b0;
		if (ext_lvl_d & ~ext_lvl_q) begin
			ext_div_d = ext_div_q + 3'h1;
			ext8_d = (ext_div_q == `SAT_DIV_EXT);
		end
		div12_d = (core_div_q == (`SAT_DIV_CORE - 4'h1));
		core_div_d = div12_d ? 4'h0 : core_div_q + 4'h1;
		lfo_fall_d = lfo_lvl_q & ~lfo_lvl_d;
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ext_sync_q <= 3'h0;
			lfo_sync_q <= 3'h0;
			ext_lvl_q <= 1'b0;
			lfo_lvl_q <= 1'b0;
			ext_div_q <= 3'h0;
			core_div_q <= 4'h0;
			ext8_q <= 1'b0;
			div12_q <= 1'b0;
			lfo_fall_q <= 1'b0;
		end else begin
			ext_sync_q <= {ext_sync_q[1:0], ext_osc_in};
			lfo_sync_q <= {lfo_sync_q[1:0], lfo_in};
			ext_lvl_q <= ext_lvl_d;
			lfo_lvl_q <= lfo_lvl_d;
			ext_div_q <= ext_div_d;
			core_div_q <= core_div_d;
			ext8_q <= ext8_d;
			div12_q <= div12_d;
			lfo_fall_q <= lfo_fall_d;
		end
	end

	// ==========================================================
	// register decode; clock config bits 3:0 belong to other timers and read zero
	logic [7:0] clk_cfg_q, clk_cfg_d;
	sat_wsel_type tb_wsel, tc_wsel;
	sat_tick_type ticks;
	sat_state_type tb_state, tc_state;

	always_comb begin
		tb_wsel.ctl = sfr_wr_in & (sfr_addr_in == `SAT_OFS_TB_CTL);
		tb_wsel.cnt_lo = sfr_wr_in & (sfr_addr_in == `SAT_OFS_TB_CNT_LO);
		tb_wsel.cnt_hi = sfr_wr_in & (sfr_addr_in == `SAT_OFS_TB_CNT_HI);
		tb_wsel.rld_lo = sfr_wr_in & (sfr_addr_in == `SAT_OFS_TB_RLD_LO);
		tb_wsel.rld_hi = sfr_wr_in & (sfr_addr_in == `SAT_OFS_TB_RLD_HI);
		tc_wsel.ctl = sfr_wr_in & (sfr_addr_in == `SAT_OFS_TC_CTL);
		tc_wsel.cnt_lo = sfr_wr_in & (sfr_addr_in == `SAT_OFS_TC_CNT_LO);
		tc_wsel.cnt_hi = sfr_wr_in & (sfr_addr_in == `SAT_OFS_TC_CNT_HI);
		tc_wsel.rld_lo = sfr_wr_in & (sfr_addr_in == `SAT_OFS_TC_RLD_LO);
		tc_wsel.rld_hi = sfr_wr_in & (sfr_addr_in == `SAT_OFS_TC_RLD_HI);
		clk_cfg_d = clk_cfg_q;
		if (sfr_wr_in && (sfr_addr_in == `SAT_OFS_CLK_CFG)) begin
			clk_cfg_d = {sfr_wdata_in[7:4], 4'h0};
		end
		ticks.div12 = div12_q;
		ticks.ext8 = ext8_q;
		ticks.lfo_fall = lfo_fall_q;
	end

	// ==========================================================
	// the two timer instances
	sat_unit u_tb (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.wsel_in(tb_wsel),
		.wdata_in(sfr_wdata_in),
		.hi_clk_sel_in(clk_cfg_q[`SAT_BIT_TB_HI_SEL]),
		.lo_clk_sel_in(clk_cfg_q[`SAT_BIT_TB_LO_SEL]),
		.irq_en_in(tb_irq_enable_in),
		.tick_in(ticks),
		.state_out(tb_state)
	);

	sat_unit u_tc (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.wsel_in(tc_wsel),
		.wdata_in(sfr_wdata_in),
		.hi_clk_sel_in(clk_cfg_q[`SAT_BIT_TC_HI_SEL]),
		.lo_clk_sel_in(clk_cfg_q[`SAT_BIT_TC_LO_SEL]),
		.irq_en_in(tc_irq_enable_in),
		.tick_in(ticks),
		.state_out(tc_state)
	);

	// ==========================================================
	// read mux and interrupt requests, both registered
	logic [7:0] rdata_d;
	logic tb_irq_d, tc_irq_d;

	always_comb begin
		case (sfr_addr_in)
			`SAT_OFS_TB_CTL: rdata_d = tb_state.ctl;
			`SAT_OFS_TB_CNT_LO: rdata_d = tb_state.count[7:0];
			`SAT_OFS_TB_CNT_HI: rdata_d = tb_state.count[15:8];
			`SAT_OFS_TB_RLD_LO: rdata_d = tb_state.reload[7:0];
			`SAT_OFS_TB_RLD_HI: rdata_d = tb_state.reload[15:8];
			`SAT_OFS_TC_CTL: rdata_d = tc_state.ctl;
			`SAT_OFS_TC_CNT_LO: rdata_d = tc_state.count[7:0];
			`SAT_OFS_TC_CNT_HI: rdata_d = tc_state.count[15:8];
			`SAT_OFS_TC_RLD_LO: rdata_d = tc_state.reload[7:0];
			`SAT_OFS_TC_RLD_HI: rdata_d = tc_state.reload[15:8];
			`SAT_OFS_CLK_CFG: rdata_d = clk_cfg_q;
			default: rdata_d = 8'h00; // unmapped reads as zero
		endcase
		// level request held while a flag stands; software clears the flag
		tb_irq_d = tb_irq_enable_in & (tb_state.ctl[`SAT_BIT_HI_FLAG] |
			(tb_state.ctl[`SAT_BIT_LO_IRQ_EN] & tb_state.ctl[`SAT_BIT_LO_FLAG]));
		tc_irq_d = tc_irq_enable_in & (tc_state.ctl[`SAT_BIT_HI_FLAG] |
			(tc_state.ctl[`SAT_BIT_LO_IRQ_EN] & tc_state.ctl[`SAT_BIT_LO_FLAG]));
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			clk_cfg_q <= `SAT_RST_BYTE;
			sfr_rdata_out <= 8'h00;
			tb_irq_out <= 1'b0;
			tc_irq_out <= 1'b0;
		end else begin
			clk_cfg_q <= clk_cfg_d;
			sfr_rdata_out <= rdata_d;
			tb_irq_out <= tb_irq_d;
			tc_irq_out <= tc_irq_d;
		end
	end
endmodule // sat_timer_pair

/* File: sat_timer_pair_properties.sv */
// Purpose: port level checks for the timer pair
// Assumes: read data lags the address by one cycle
// Notes: bound onto every sat_timer_pair
`timescale 1ns/1ns
`include "sat_timer_regs.svh"
module sat_timer_pair_properties (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic [7:0] sfr_addr_in,
	input wire logic sfr_wr_in,
	input wire logic [7:0] sfr_wdata_in,
	input wire logic [7:0] sfr_rdata_out,
	input wire logic ext_osc_in,
	input wire logic lfo_in,
	input wire logic tb_irq_enable_in,
	input wire logic tc_irq_enable_in,
	input wire logic tb_irq_out,
	input wire logic tc_irq_out
);
	// ==========================================================
	// one clock domain, so one default clocking and disable
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!rst_n_in);
	a_unused_bit_zero: assert property ((sfr_addr_in == `SAT_OFS_TB_CTL ||
		sfr_addr_in == `SAT_OFS_TC_CTL) |=> !sfr_rdata_out[1])
		else $error("unused control bit read high");
	a_cfg_nibble_zero: assert property (sfr_addr_in == `SAT_OFS_CLK_CFG |=>
		sfr_rdata_out[3:0] == 4'h0) else $error("clock config low nibble not zero");
	a_unmapped_reads_zero: assert property (sfr_addr_in > `SAT_OFS_CLK_CFG |=>
		sfr_rdata_out == 8'h00) else $error("unmapped address read nonzero");
	// reload bytes only change by write or capture, so a readback is exact
	a_reload_readback: assert property ((sfr_wr_in && sfr_addr_in == `SAT_OFS_TB_RLD_LO) ##1
		(sfr_addr_in == `SAT_OFS_TB_RLD_LO && !sfr_wr_in) |=>
		sfr_rdata_out == $past(sfr_wdata_in, 2)) else $error("reload byte readback wrong");
	a_ctl_write_back: assert property ((sfr_wr_in && sfr_addr_in == `SAT_OFS_TB_CTL) ##1
		(sfr_addr_in == `SAT_OFS_TB_CTL && !sfr_wr_in) |=>
		sfr_rdata_out[5:0] == ($past(sfr_wdata_in[5:0], 2) & 6'h3D))
		else $error("control readback wrong");
	// the flag seen now was stored two edges back, so the edge in between must hold no write
	a_flag_sticky: assert property ((sfr_addr_in == `SAT_OFS_TB_CTL && !$past(sfr_wr_in) &&
		sfr_rdata_out[7] && $past(sfr_addr_in) == `SAT_OFS_TB_CTL) |=> sfr_rdata_out[7])
		else $error("high flag cleared without a write");
	a_high_flag_irq: assert property (($past(sfr_addr_in) == `SAT_OFS_TB_CTL &&
		sfr_rdata_out[7] && $past(tb_irq_enable_in)) |-> tb_irq_out)
		else $error("high flag without interrupt");
	a_low_flag_irq: assert property (($past(sfr_addr_in) == `SAT_OFS_TB_CTL &&
		sfr_rdata_out[6] && sfr_rdata_out[5] && $past(tb_irq_enable_in)) |-> tb_irq_out)
		else $error("enabled low flag without interrupt");
	a_no_flag_quiet: assert property (($past(sfr_addr_in) == `SAT_OFS_TB_CTL &&
		!sfr_rdata_out[7] && !(sfr_rdata_out[6] && sfr_rdata_out[5])) |-> !tb_irq_out)
		else $error("interrupt without an enabled flag");
	a_tc_irq_gate: assert property (!$past(tc_irq_enable_in) |-> !tc_irq_out)
		else $error("interrupt while disabled");
endmodule // sat_timer_pair_properties

bind sat_timer_pair sat_timer_pair_properties chk_u (.clk_in(clk_in), .rst_n_in(rst_n_in),
	.sfr_addr_in(sfr_addr_in), .sfr_wr_in(sfr_wr_in), .sfr_wdata_in(sfr_wdata_in),
	.sfr_rdata_out(sfr_rdata_out), .ext_osc_in(ext_osc_in), .lfo_in(lfo_in),
	.tb_irq_enable_in(tb_irq_enable_in), .tc_irq_enable_in(tc_irq_enable_in),
	.tb_irq_out(tb_irq_out), .tc_irq_out(tc_irq_out));

/* File: sat_timer_regs.svh */
// Purpose: constants for the split auto-reload timer pair
// Assumes: 8-bit special function register port, 50 MHz core clock
// Notes: definitions only
`ifndef SAT_TIMER_REGS_SVH
`define SAT_TIMER_REGS_SVH

// ==========================================================
// register offsets on the special function register port
`define SAT_OFS_TB_CTL 8'h00
`define SAT_OFS_TB_CNT_LO 8'h01
`define SAT_OFS_TB_CNT_HI 8'h02
`define SAT_OFS_TB_RLD_LO 8'h03
`define SAT_OFS_TB_RLD_HI 8'h04
`define SAT_OFS_TC_CTL 8'h05
`define SAT_OFS_TC_CNT_LO 8'h06
`define SAT_OFS_TC_CNT_HI 8'h07
`define SAT_OFS_TC_RLD_LO 8'h08
`define SAT_OFS_TC_RLD_HI 8'h09
`define SAT_OFS_CLK_CFG 8'h0A

// ==========================================================
// control register field positions
`define SAT_BIT_HI_FLAG 7
`define SAT_BIT_LO_FLAG 6
`define SAT_BIT_LO_IRQ_EN 5
`define SAT_BIT_CAP_EN 4
`define SAT_BIT_SPLIT 3
`define SAT_BIT_RUN 2
`define SAT_BIT_EXT_SEL 0
// clock config field positions
`define SAT_BIT_TC_HI_SEL 7
`define SAT_BIT_TC_LO_SEL 6
`define SAT_BIT_TB_HI_SEL 5
`define SAT_BIT_TB_LO_SEL 4

// ==========================================================
// reset values, control write mask and timing counts
`define SAT_RST_BYTE 8'h00
`define SAT_CTL_WMASK 8'hFD
`define SAT_DIV_CORE 4'hC
`define SAT_DIV_EXT 3'h7
`endif

/* File: sat_unit.sv */
// Purpose: one 16-bit / dual 8-bit auto-reload timer
// Assumes: ticks are one-cycle pulses on clk_in
// Notes: software writes win over counting in the same cycle
`timescale 1ns/1ns
`include "sat_timer_regs.svh"
module sat_unit (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire sat_pkg::sat_wsel_type wsel_in,
	input wire logic [7:0] wdata_in,
	input wire logic hi_clk_sel_in,
	input wire logic lo_clk_sel_in,
	input wire logic irq_en_in,
	input wire sat_pkg::sat_tick_type tick_in,
	output sat_pkg::sat_state_type state_out
);
	import sat_pkg::*;

	logic [7:0] ctl_q, ctl_d;
	logic [7:0] lo_q, lo_d, hi_q, hi_d;
	logic [7:0] rl_lo_q, rl_lo_d, rl_hi_q, rl_hi_d;
	logic split, run, ext_sel, lo_tick, hi_tick, inc_lo, inc_hi;
	logic lo_ovf, hi_ovf, cap_ev;

	// ==========================================================
	// count sources and overflow detection
	always_comb begin
		split = ctl_q[`SAT_BIT_SPLIT];
		run = ctl_q[`SAT_BIT_RUN];
		ext_sel = ctl_q[`SAT_BIT_EXT_SEL];
		lo_tick = lo_clk_sel_in | (ext_sel ? tick_in.ext8 : tick_in.div12);
		hi_tick = hi_clk_sel_in | (ext_sel ? tick_in.ext8 : tick_in.div12);
		if (split) begin
			inc_lo = lo_tick;
			inc_hi = run & hi_tick;
		end else begin
			inc_lo = run & lo_tick;
			inc_hi = inc_lo & (lo_q == 8'hFF);
		end
		lo_ovf = inc_lo & (lo_q == 8'hFF);
		hi_ovf = inc_hi & (hi_q == 8'hFF);
		cap_ev = ctl_q[`SAT_BIT_CAP_EN] & irq_en_in & tick_in.lfo_fall;
	end

	// ==========================================================
	// next values; hardware flag sets win over a software clear
	always_comb begin
		ctl_d = wsel_in.ctl ? (wdata_in & `SAT_CTL_WMASK) : ctl_q;
		ctl_d[`SAT_BIT_HI_FLAG] = ctl_d[`SAT_BIT_HI_FLAG] | hi_ovf | cap_ev;
		ctl_d[`SAT_BIT_LO_FLAG] = ctl_d[`SAT_BIT_LO_FLAG] | lo_ovf;
		lo_d = lo_q;
		hi_d = hi_q;
		if (split) begin
			if (inc_lo) begin
				lo_d = lo_ovf ? rl_lo_q : lo_q + 8'h01;
			end
			if (inc_hi) begin
				hi_d = hi_ovf ? rl_hi_q : hi_q + 8'h01;
			end
		end else if (hi_ovf) begin
			lo_d = rl_lo_q;
			hi_d = rl_hi_q;
		end else if (inc_lo) begin
			lo_d = lo_q + 8'h01;
			hi_d = inc_hi ? hi_q + 8'h01 : hi_q;
		end
		if (wsel_in.cnt_lo) begin
			lo_d = wdata_in;
		end
		if (wsel_in.cnt_hi) begin
			hi_d = wdata_in;
		end
		rl_lo_d = wsel_in.rld_lo ? wdata_in : rl_lo_q;
		rl_hi_d = wsel_in.rld_hi ? wdata_in : rl_hi_q;
		// capture beats a software write to the reload bytes
		if (cap_ev) begin
			rl_lo_d = lo_q;
			rl_hi_d = hi_q;
		end
	end

	// ==========================================================
	// state registers
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ctl_q <= `SAT_RST_BYTE;
			lo_q <= `SAT_RST_BYTE;
			hi_q <= `SAT_RST_BYTE;
			rl_lo_q <= `SAT_RST_BYTE;
			rl_hi_q <= `SAT_RST_BYTE;
		end else begin
			ctl_q <= ctl_d;
			lo_q <= lo_d;
			hi_q <= hi_d;
			rl_lo_q <= rl_lo_d;
			rl_hi_q <= rl_hi_d;
		end
	end

	assign state_out = '{ctl: ctl_q, count: {hi_q, lo_q}, reload: {rl_hi_q, rl_lo_q}};
endmodule // sat_unit

/* File: tb.sv */
// Purpose: self-checking bench for the timer pair
// Assumes: 50 MHz clock, registers reached by address
// Notes: read data is compared one cycle after the address
`timescale 1ns/1ns
`include "sat_timer_regs.svh"
`define CHK(a, e, m, g) begin check_count++; if ((g & m) !== (e & m)) begin n_errors++; \
	$display("mismatch reg %h exp %h got %h", a, e, g); end end
module tb;
	import sat_pkg::*;
	logic clk_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic wr = 1'b0;
	logic ext_osc = 1'b0;
	logic lfo = 1'b0;
	logic tb_en = 1'b1;
	logic tc_en = 1'b0;
	logic look = 1'b0;
	logic [7:0] rdata;
	logic [7:0] r;
	logic [7:0] seen;
	logic tb_irq;
	logic tc_irq;
	logic [23:0] note;
	logic [23:0] exp_q[$];
	int n_errors = 0;
	int check_count = 0;
	// ==========================================================
	// clock, device and result watcher
	initial begin
		forever #10 clk_in = ~clk_in;
	end
	sat_timer_pair dut_u (.clk_in(clk_in), .rst_n_in(rst_n_in), .sfr_addr_in(addr),
		.sfr_wr_in(wr), .sfr_wdata_in(wdata), .sfr_rdata_out(rdata), .ext_osc_in(ext_osc),
		.lfo_in(lfo), .tb_irq_enable_in(tb_en), .tc_irq_enable_in(tc_en),
		.tb_irq_out(tb_irq), .tc_irq_out(tc_irq));
	// read data is settled by the falling edge, so compare there
	always @(negedge clk_in) begin
		if (look) begin
			look = 1'b0;
			note = exp_q.pop_front();
			// pseudo addresses F0 and F1 stand for the two interrupt outputs
			seen = rdata;
			if (note[23:16] == 8'hF0) begin
				seen = {7'h00, tb_irq};
			end else if (note[23:16] == 8'hF1) begin
				seen = {7'h00, tc_irq};
			end
			`CHK(note[23:16], note[7:0], note[15:8], seen)
		end
	end
	// ==========================================================
	// register port tasks; write strobe lasts exactly one cycle
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_in);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk_in);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
		exp_q.push_back({a, m, e});
		@(posedge clk_in);
		addr <= a;
		@(posedge clk_in);
		look <= 1'b1;
	endtask
	// interrupt level compared at the falling edge after the next rising edge
	task automatic irq_chk(input logic [7:0] a, input logic e);
		exp_q.push_back({a, 8'h01, 7'h00, e});
		@(posedge clk_in);
		look <= 1'b1;
	endtask
	task automatic test_done();
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// watchdog at 10000 cycles, well beyond the few hundred cycles the tests need
	initial begin
		#200000;
		n_errors++;
		test_done();
	end
	// ==========================================================
	// test sequence
	initial begin
		void'($urandom(32'h818a3cda));
		repeat (3) @(posedge clk_in);
		rst_n_in <= 1'b1;
		for (int i = 0; i < 12; i++) begin
			rd_reg(i[7:0], 8'h00, 8'hFF);
		end
		$display("reset values done");
		for (int i = 1; i < 9; i++) begin
			r = 8'($urandom());
			wr_reg((i < 5) ? i[7:0] : i[7:0] + 8'h01, r);
			rd_reg((i < 5) ? i[7:0] : i[7:0] + 8'h01, r, 8'hFF);
		end
		$display("byte access done");
		wr_reg(`SAT_OFS_TB_CTL, 8'hE2);
		rd_reg(`SAT_OFS_TB_CTL, 8'hE0, 8'hFF);
		rd_reg(`SAT_OFS_TB_CTL, 8'hE0, 8'hFF);
		irq_chk(8'hF0, 1'b1);
		wr_reg(`SAT_OFS_TC_CTL, 8'h80);
		tc_en <= 1'b1;
		irq_chk(8'hF1, 1'b1);
		wr_reg(`SAT_OFS_TC_CTL, 8'h00);
		wr_reg(`SAT_OFS_TB_CTL, 8'h00);
		rd_reg(`SAT_OFS_TB_CTL, 8'h00, 8'hFF);
		irq_chk(8'hF0, 1'b0);
		irq_chk(8'hF1, 1'b0);
		$display("control bits done");
		// full 16-bit roll, high clock select left at divided clock
		wr_reg(`SAT_OFS_CLK_CFG, 8'h10);
		wr_reg(`SAT_OFS_TB_RLD_LO, 8'h34);
		wr_reg(`SAT_OFS_TB_RLD_HI, 8'h12);
		wr_reg(`SAT_OFS_TB_CNT_LO, 8'hFE);
		wr_reg(`SAT_OFS_TB_CNT_HI, 8'hFF);
		wr_reg(`SAT_OFS_TB_CTL, 8'h04);
		@(posedge clk_in);
		rd_reg(`SAT_OFS_TB_CTL, 8'hC4, 8'hFF);
		wr_reg(`SAT_OFS_TB_CTL, 8'h00);
		rd_reg(`SAT_OFS_TB_CNT_HI, 8'h12, 8'hFF);
		$display("16-bit reload done");
		// split: both bytes roll on their own, no carry between them
		wr_reg(`SAT_OFS_TB_RLD_LO, 8'h50);
		wr_reg(`SAT_OFS_TB_RLD_HI, 8'hA0);
		wr_reg(`SAT_OFS_TB_CNT_LO, 8'hFF);
		wr_reg(`SAT_OFS_TB_CNT_HI, 8'hFF);
		wr_reg(`SAT_OFS_CLK_CFG, 8'h30);
		wr_reg(`SAT_OFS_TB_CTL, 8'h0C);
		rd_reg(`SAT_OFS_TB_CNT_LO, 8'h50, 8'hF0);
		rd_reg(`SAT_OFS_TB_CNT_HI, 8'hA0, 8'hF0);
		rd_reg(`SAT_OFS_TB_CTL, 8'hCC, 8'hFF);
		$display("split roll done");
		// low byte on core/12 with run off; high byte must stay put
		wr_reg(`SAT_OFS_TB_CTL, 8'h08);
		wr_reg(`SAT_OFS_CLK_CFG, 8'h00);
		wr_reg(`SAT_OFS_TB_CNT_LO, 8'h00);
		wr_reg(`SAT_OFS_TB_CNT_HI, 8'h00);
		repeat (300) @(posedge clk_in);
		rd_reg(`SAT_OFS_TB_CNT_LO, 8'h18, 8'hFC);
		rd_reg(`SAT_OFS_TB_CNT_HI, 8'h00, 8'hFF);
		$display("split run gate done");
		// sixteen rising oscillator edges give two synchronised ticks
		wr_reg(`SAT_OFS_TC_CNT_LO, 8'h00);
		wr_reg(`SAT_OFS_TC_CNT_HI, 8'h00);
		wr_reg(`SAT_OFS_TC_CTL, 8'h05);
		for (int i = 0; i < 32; i++) begin
			repeat (3) @(posedge clk_in);
			ext_osc <= ~ext_osc;
		end
		repeat (10) @(posedge clk_in);
		rd_reg(`SAT_OFS_TC_CNT_LO, 8'h02, 8'hFF);
		$display("external source done");
		wr_reg(`SAT_OFS_TB_CTL, 8'h00);
		wr_reg(`SAT_OFS_CLK_CFG, 8'h10);
		wr_reg(`SAT_OFS_TB_CNT_LO, 8'h00);
		wr_reg(`SAT_OFS_TB_CNT_HI, 8'h70);
		wr_reg(`SAT_OFS_TB_CTL, 8'h14);
		lfo <= 1'b1;
		repeat (10) @(posedge clk_in);
		lfo <= 1'b0;
		repeat (10) @(posedge clk_in);
		rd_reg(`SAT_OFS_TB_CTL, 8'h94, 8'hFF);
		rd_reg(`SAT_OFS_TB_RLD_HI, 8'h70, 8'hFF);
		irq_chk(8'hF0, 1'b1);
		repeat (2) @(posedge clk_in);
		$display("capture done");
		test_done();
	end
endmodule // tb
